// ==== shared/clock_buffer_regs.svh ====
// Purpose: offsets, field positions, reset values of the upper config bytes
// Assumes: one index per byte, as seen over the serial management link
// Notes: definitions only
`ifndef CLOCK_BUFFER_REGS_SVH
`define CLOCK_BUFFER_REGS_SVH

`define OFS_OUTPUT_ENABLE_GROUP_B 8'h02
`define OFS_RESERVED_THREE        8'h03
`define OFS_RESERVED_FOUR         8'h04
`define OFS_REVISION_AND_VENDOR   8'h05
`define OFS_PART_IDENTITY         8'h06
`define OFS_READBACK_LENGTH       8'h07

`define POS_PAIR_SEVEN_ENABLE     2
`define POS_PAIR_SIX_ENABLE       0
`define POS_COUNT_BIT_FOUR        4
`define POS_REVISION_BIT_ZERO     4

`define RST_PAIR_SEVEN_ENABLE     1'b1
`define RST_PAIR_SIX_ENABLE       1'b1
`define RST_READBACK_LENGTH       5'h08
`define RST_RESERVED_BYTE         8'h00

`define BITS_PER_BYTE             4'h8
`define LAST_BIT_INDEX            4'h7

`endif

// ==== shared/clock_buffer_pkg.sv ====
// Purpose: types shared by the config register bank and its line watcher
// Assumes: nothing
// Notes: state machines use one-hot codes
package clock_buffer_pkg;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'b0000001,
        ST_ADDR     = 7'b0000010,
        ST_ADDR_ACK = 7'b0000100,
        ST_RX       = 7'b0001000,
        ST_RX_ACK   = 7'b0010000,
        ST_TX       = 7'b0100000,
        ST_TX_ACK   = 7'b1000000
    } link_state_e;

    typedef enum logic [2:0] {
        KIND_INDEX = 3'b001,
        KIND_COUNT = 3'b010,
        KIND_DATA  = 3'b100
    } byte_kind_e;

    typedef struct packed {
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } line_s;

    typedef struct packed {
        link_state_e fsm;
        byte_kind_e  kind;
        logic [7:0]  shift;
        logic [3:0]  cnt;
        logic [7:0]  ptr;
        logic        rd;
        logic        first;
        logic        more;
        logic        sda_oe;
        logic        sda_val;
        logic        en6;
        logic        en7;
        logic [4:0]  count;
        logic        run6;
        logic        run7;
    } bank_s;

endpackage

// ==== hdl/smbus_line_watch.sv ====
// Purpose: turns sampled clock and data lines into edge and framing events
// Assumes: scl_in and sda_in already synchronous to clk
// Notes: events last one enabled cycle and line up with the registered sda
`timescale 1ns/1ps
`default_nettype none
module smbus_line_watch
    import clock_buffer_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output line_s     line_ev
);
    line_s st_reg;
    line_s st_next;

    always_comb begin
        st_next = st_reg;
        if (clk_en) begin
            st_next.scl   = scl_in;
            st_next.sda   = sda_in;
            st_next.rise  = scl_in & ~st_reg.scl;
            st_next.fall  = ~scl_in & st_reg.scl;
            // data moving while the clock stays high frames a transfer
            st_next.start = scl_in & st_reg.scl & st_reg.sda & ~sda_in;
            st_next.stop  = scl_in & st_reg.scl & ~st_reg.sda & sda_in;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign line_ev = st_reg;

    chk_start_needs_high: assert property (@(posedge clk) disable iff (sys_rst)
        st_reg.start |-> st_reg.scl && !st_reg.sda)
        else $error("start event without high clock and low data");
endmodule
`default_nettype wire

// ==== hdl/clock_buffer_smbus_regs_upper.sv ====
// Purpose: upper config bytes (2 to 7) of a differential clock buffer,
//          reached over its two-wire management port
// Assumes: scl_in/sda_in synchronous to clk; sda is open drain
// Notes: indices outside 2..7 read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "clock_buffer_regs.svh"

// Notes on behaviour
// - output_enable_group_b bit 2 gates pair seven
// - output_enable_group_b bit 0 gates pair six
// - revision_and_vendor returns revision and vendor codes
// - part_identity returns the device identity code
// - readback_length low five bits: block read count
// - reserved_three is reserved, reads zero
// - reserved_four is reserved, reads zero
// - block read sends count, then bytes from index
module clock_buffer_smbus_regs_upper
    import clock_buffer_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h6c,
    // arbitrary neutral values
    parameter logic [3:0] REVISION   = 4'h2,
    parameter logic [3:0] VENDOR     = 4'h5,
    parameter logic [7:0] DEVICE_ID  = 8'h5a
)(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic pair_six_oe_n,
    input  wire logic pair_seven_oe_n,
    output logic      pair_six_run,
    output logic      pair_seven_run
);
    localparam bank_s BANK_RESET = '{
        fsm:     ST_IDLE,
        kind:    KIND_INDEX,
        shift:   8'h00,
        cnt:     4'h0,
        ptr:     8'h00,
        rd:      1'b0,
        first:   1'b0,
        more:    1'b0,
        sda_oe:  1'b0,
        sda_val: 1'b0,
        en6:     `RST_PAIR_SIX_ENABLE,
        en7:     `RST_PAIR_SEVEN_ENABLE,
        count:   `RST_READBACK_LENGTH,
        run6:    1'b0,
        run7:    1'b0
    };

    line_s line_ev;
    bank_s st_reg;
    bank_s st_next;
    logic  tx_load;
    logic  [7:0] tx_byte;

    smbus_line_watch u_line (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .line_ev (line_ev)
    );

    // read view of one byte index
    function automatic logic [7:0] read_byte(input bank_s s,
                                             input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            `OFS_OUTPUT_ENABLE_GROUP_B: begin
                v[`POS_PAIR_SEVEN_ENABLE] = s.en7;
                v[`POS_PAIR_SIX_ENABLE]   = s.en6;
            end
            `OFS_RESERVED_THREE:      v = `RST_RESERVED_BYTE;
            `OFS_RESERVED_FOUR:       v = `RST_RESERVED_BYTE;
            `OFS_REVISION_AND_VENDOR: v = {REVISION, VENDOR};
            `OFS_PART_IDENTITY:       v = DEVICE_ID;
            `OFS_READBACK_LENGTH:     v = {3'h0, s.count};
            default:                  v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        st_next = st_reg;
        tx_load = 1'b0;
        tx_byte = 8'h00;
        if (clk_en) begin
            st_next.run6 = st_reg.en6 & ~pair_six_oe_n;
            st_next.run7 = st_reg.en7 & ~pair_seven_oe_n;
            if (line_ev.stop) begin
                st_next.fsm    = ST_IDLE;
                st_next.sda_oe = 1'b0;
            end else if (line_ev.start) begin
                st_next.fsm    = ST_ADDR;
                st_next.cnt    = 4'h0;
                st_next.sda_oe = 1'b0;
            end else begin
                case (st_reg.fsm)
                    ST_ADDR, ST_RX: begin
                        if (line_ev.rise) begin
                            st_next.shift = {st_reg.shift[6:0], line_ev.sda};
                            st_next.cnt   = st_reg.cnt + 4'h1;
                        end else if (line_ev.fall &&
                                     st_reg.cnt == `BITS_PER_BYTE) begin
                            if (st_reg.fsm == ST_ADDR) begin
                                if (st_reg.shift[7:1] == SLAVE_ADDR) begin
                                    st_next.rd     = st_reg.shift[0];
                                    st_next.first  = 1'b1;
                                    st_next.kind   = KIND_INDEX;
                                    st_next.sda_oe = 1'b1;
                                    st_next.fsm    = ST_ADDR_ACK;
                                end else begin
                                    st_next.fsm = ST_IDLE;
                                end
                            end else begin
                                st_next.sda_oe = 1'b1;
                                st_next.fsm    = ST_RX_ACK;
                                case (st_reg.kind)
                                    KIND_INDEX: begin
                                        st_next.ptr  = st_reg.shift;
                                        st_next.kind = KIND_COUNT;
                                    end
                                    KIND_COUNT: begin
                                        st_next.kind = KIND_DATA;
                                    end
                                    KIND_DATA: begin
                                        st_next.ptr = st_reg.ptr + 8'h01;
                                        case (st_reg.ptr)
                                            `OFS_OUTPUT_ENABLE_GROUP_B: begin
                                                st_next.en7 = st_reg.shift[
                                                    `POS_PAIR_SEVEN_ENABLE];
                                                st_next.en6 = st_reg.shift[
                                                    `POS_PAIR_SIX_ENABLE];
                                            end
                                            `OFS_READBACK_LENGTH: begin
                                                st_next.count = st_reg.shift[
                                                    `POS_COUNT_BIT_FOUR:0];
                                            end
                                            default: begin
                                                st_next.count = st_reg.count;
                                            end
                                        endcase
                                    end
                                    default: st_next.kind = KIND_INDEX;
                                endcase
                            end
                        end
                    end
                    ST_ADDR_ACK, ST_RX_ACK: begin
                        if (line_ev.fall) begin
                            st_next.sda_oe = 1'b0;
                            st_next.cnt    = 4'h0;
                            if (st_reg.fsm == ST_ADDR_ACK && st_reg.rd) begin
                                tx_load = 1'b1;
                            end else begin
                                st_next.fsm = ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (line_ev.fall) begin
                            if (st_reg.cnt == `LAST_BIT_INDEX) begin
                                st_next.sda_oe = 1'b0;
                                st_next.fsm    = ST_TX_ACK;
                            end else begin
                                st_next.shift  = {st_reg.shift[6:0], 1'b0};
                                st_next.cnt    = st_reg.cnt + 4'h1;
                                st_next.sda_oe = ~st_reg.shift[6];
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        if (line_ev.rise) begin
                            st_next.more = ~line_ev.sda;
                        end else if (line_ev.fall) begin
                            if (st_reg.more) begin
                                tx_load = 1'b1;
                            end else begin
                                st_next.fsm = ST_IDLE;
                            end
                        end
                    end
                    ST_IDLE: st_next.sda_oe = 1'b0;
                    default: st_next.fsm = ST_IDLE;
                endcase
            end
            if (tx_load) begin
                // count goes first, then bytes from the index onward
                if (st_reg.first) begin
                    tx_byte = {3'h0, st_reg.count};
                end else begin
                    tx_byte = read_byte(st_reg, st_reg.ptr);
                    st_next.ptr = st_reg.ptr + 8'h01;
                end
                st_next.first  = 1'b0;
                st_next.shift  = tx_byte;
                st_next.cnt    = 4'h0;
                st_next.sda_oe = ~tx_byte[7];
                st_next.fsm    = ST_TX;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= BANK_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sda_out        = st_reg.sda_val;
    assign sda_oe         = st_reg.sda_oe;
    assign pair_six_run   = st_reg.run6;
    assign pair_seven_run = st_reg.run7;

    chk_pair_seven_off: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !st_reg.en7 |=> !pair_seven_run)
        else $error("pair seven runs while its enable is clear");
    chk_pair_six_off: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && (!st_reg.en6 || pair_six_oe_n) |=> !pair_six_run)
        else $error("pair six runs while disabled");
    chk_rev_vendor_read: assert property (@(posedge clk) disable iff (sys_rst)
        tx_load && !st_reg.first && st_reg.ptr == `OFS_REVISION_AND_VENDOR
        |=> st_reg.shift == {REVISION, VENDOR})
        else $error("revision and vendor byte wrong");
    chk_part_id_read: assert property (@(posedge clk) disable iff (sys_rst)
        tx_load && !st_reg.first && st_reg.ptr == `OFS_PART_IDENTITY
        |=> st_reg.shift == DEVICE_ID && st_reg.sda_oe == !DEVICE_ID[7])
        else $error("identity byte or its first bit wrong");
    chk_count_first: assert property (@(posedge clk) disable iff (sys_rst)
        tx_load && st_reg.first
        |=> st_reg.shift == {3'h0, $past(st_reg.count)} && !st_reg.first)
        else $error("block read did not open with the count");
    chk_byte3_zero: assert property (@(posedge clk) disable iff (sys_rst)
        tx_load && !st_reg.first && st_reg.ptr == `OFS_RESERVED_THREE
        |=> st_reg.shift == 8'h00)
        else $error("reserved byte three reads nonzero");
    chk_byte4_zero: assert property (@(posedge clk) disable iff (sys_rst)
        tx_load && !st_reg.first && st_reg.ptr == `OFS_RESERVED_FOUR
        |=> st_reg.shift == 8'h00)
        else $error("reserved byte four reads nonzero");
    chk_index_walks: assert property (@(posedge clk) disable iff (sys_rst)
        tx_load && !st_reg.first
        |=> st_reg.ptr == $past(st_reg.ptr) + 8'h01 && st_reg.fsm == ST_TX)
        else $error("read index did not advance");
    chk_rsvd_bits_zero: assert property (@(posedge clk) disable iff (sys_rst)
        tx_load && !st_reg.first && st_reg.ptr == `OFS_OUTPUT_ENABLE_GROUP_B
        |=> st_reg.shift[7:3] == 5'h00 && !st_reg.shift[1])
        else $error("reserved bits of byte two read nonzero");
endmodule
`default_nettype wire

// ==== verif/smbus_host_model.sv ====
// Purpose: behavioural host on the two-wire management link
// Assumes: line level is worked out outside and fed back on sda_line
// Notes: all line changes land on the falling edge of clk
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // each clock phase lasts well over the three cycles the device needs
    localparam int HALF = 8;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask

    // data changes only while scl is low, sampled just before scl falls
    task automatic send_bit(input logic b, output logic seen);
        hold(2);
        sda_low = ~b;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        seen = sda_line;
        scl = 1'b0;
    endtask

    // also serves as repeated start when scl is low
    task automatic start_cond();
        hold(2);
        sda_low = 1'b0;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sda_low = 1'b1;
        hold(HALF);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        hold(2);
        sda_low = 1'b1;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sda_low = 1'b0;
        hold(HALF);
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i], s);
        end
        send_bit(1'b1, s);
        ack = ~s;
    endtask

    // host acks a byte only when ack is set, a nack ends the read
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(1'b1, s);
            d[i] = s;
        end
        send_bit(~ack, s);
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench for the upper config bytes
// Assumes: open-drain data line with pull-up, host model drives the clock line
// Notes: identity parameters get arbitrary values of our own
`timescale 1ns/1ps
`default_nettype none
`include "clock_buffer_regs.svh"
module tb_top
    import clock_buffer_pkg::*;
;
    localparam logic [6:0] ADDR = 7'h35;
    // arbitrary values
    localparam logic [3:0] REV  = 4'h3;
    localparam logic [3:0] VEN  = 4'h9;
    localparam logic [7:0] DEV  = 8'h6b;

    logic clk;
    logic sys_rst;
    logic clk_en;
    logic scl;
    logic host_sda_low;
    logic sda_in;
    logic sda_out;
    logic sda_oe;
    logic six_oe_n;
    logic seven_oe_n;
    logic six_run;
    logic seven_run;
    int   n_errors;
    int   checks_done;

    // released line floats high through the pull-up
    assign sda_in = ~(host_sda_low | (sda_oe & ~sda_out));

    clock_buffer_smbus_regs_upper #(
        .SLAVE_ADDR(ADDR),
        .REVISION  (REV),
        .VENDOR    (VEN),
        .DEVICE_ID (DEV)
    ) u_clock_buffer_smbus_regs_upper (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .clk_en         (clk_en),
        .scl_in         (scl),
        .sda_in         (sda_in),
        .sda_out        (sda_out),
        .sda_oe         (sda_oe),
        .pair_six_oe_n  (six_oe_n),
        .pair_seven_oe_n(seven_oe_n),
        .pair_six_run   (six_run),
        .pair_seven_run (seven_run)
    );

    smbus_host_model u_smbus_host_model (
        .clk     (clk),
        .sda_line(sda_in),
        .scl     (scl),
        .sda_low (host_sda_low)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic write_seq(input logic [7:0] idx, input logic [7:0] d,
                             input int n);
        logic a;
        u_smbus_host_model.start_cond();
        u_smbus_host_model.put_byte({ADDR, 1'b0}, a);
        check({7'h0, a}, 8'h01);
        u_smbus_host_model.put_byte(idx, a);
        check({7'h0, a}, 8'h01);
        u_smbus_host_model.put_byte(8'(n), a);
        check({7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            u_smbus_host_model.put_byte(d, a);
            check({7'h0, a}, 8'h01);
        end
        u_smbus_host_model.stop_cond();
    endtask

    // q[0] takes the count byte, q[1..n] the data bytes
    task automatic read_seq(input logic [7:0] idx, input int n,
                            output logic [7:0] q [0:8]);
        logic a;
        u_smbus_host_model.start_cond();
        u_smbus_host_model.put_byte({ADDR, 1'b0}, a);
        u_smbus_host_model.put_byte(idx, a);
        u_smbus_host_model.start_cond();
        u_smbus_host_model.put_byte({ADDR, 1'b1}, a);
        check({7'h0, a}, 8'h01);
        for (int i = 0; i <= n; i++) begin
            u_smbus_host_model.get_byte(i < n, q[i]);
        end
        u_smbus_host_model.stop_cond();
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        $display("watchdog expired at t=%0t", $time);
        complete_run();
    end

    initial begin
        logic [7:0] q [0:8];
        logic       a;
        clk_en = 1'b1;
        sys_rst = 1'b1;
        six_oe_n = 1'b0;
        seven_oe_n = 1'b0;
        n_errors = 0;
        checks_done = 0;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        check({6'h0, seven_run, six_run}, 8'h03);
        read_seq(`OFS_OUTPUT_ENABLE_GROUP_B, 6, q);
        check(q[0], 8'h08);
        check(q[1], 8'h05);
        check(q[2], 8'h00);
        check(q[3], 8'h00);
        check(q[4], {REV, VEN});
        check(q[5], DEV);
        check(q[6], 8'h08);
        $display("test reset_map done");

        // reserved bits of the enable register written high each time
        for (int e = 0; e < 4; e++) begin
            write_seq(`OFS_OUTPUT_ENABLE_GROUP_B, {5'h1f, e[1], 1'b1, e[0]}, 1);
            read_seq(`OFS_OUTPUT_ENABLE_GROUP_B, 1, q);
            check(q[1], {5'h00, e[1], 1'b0, e[0]});
            for (int p = 0; p < 4; p++) begin
                {seven_oe_n, six_oe_n} = 2'(p);
                repeat (3) @(negedge clk);
                check({7'h0, seven_run}, {7'h0, e[1] & ~p[1]});
                check({7'h0, six_run}, {7'h0, e[0] & ~p[0]});
            end
            {seven_oe_n, six_oe_n} = 2'b00;
        end
        $display("test enable_override done");

        write_seq(`OFS_RESERVED_THREE, 8'hff, 4);
        read_seq(`OFS_RESERVED_THREE, 4, q);
        check(q[1], 8'h00);
        check(q[2], 8'h00);
        check(q[3], {REV, VEN});
        check(q[4], DEV);
        $display("test read_only done");

        write_seq(`OFS_READBACK_LENGTH, 8'hff, 1);
        read_seq(`OFS_READBACK_LENGTH, 1, q);
        check(q[0], 8'h1f);
        check(q[1], 8'h1f);
        write_seq(`OFS_READBACK_LENGTH, 8'h03, 1);
        read_seq(`OFS_REVISION_AND_VENDOR, 2, q);
        check(q[0], 8'h03);
        check(q[1], {REV, VEN});
        check(q[2], DEV);
        $display("test byte_count done");

        // frozen state must ignore the pin until the enable returns
        clk_en = 1'b0;
        seven_oe_n = 1'b1;
        repeat (4) @(negedge clk);
        check({7'h0, seven_run}, 8'h01);
        clk_en = 1'b1;
        repeat (3) @(negedge clk);
        check({7'h0, seven_run}, 8'h00);
        check({7'h0, sda_out}, 8'h00);
        seven_oe_n = 1'b0;
        repeat (3) @(negedge clk);
        $display("test clock_enable done");

        u_smbus_host_model.start_cond();
        u_smbus_host_model.put_byte({ADDR ^ 7'h01, 1'b0}, a);
        check({7'h0, a}, 8'h00);
        u_smbus_host_model.stop_cond();
        $display("test foreign_address done");

        write_seq(`OFS_OUTPUT_ENABLE_GROUP_B, 8'h00, 1);
        repeat (3) @(negedge clk);
        check({6'h0, seven_run, six_run}, 8'h00);
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        check({6'h0, seven_run, six_run}, 8'h03);
        read_seq(`OFS_READBACK_LENGTH, 1, q);
        check(q[0], 8'h08);
        $display("test second_reset done");
        complete_run();
    end
endmodule
`default_nettype wire
